// file: verilog/cef_pkg.sv
package cef_pkg;

   // Bus geometry
   localparam int ADR_W = 12;
   localparam int DAT_W = 32;
   localparam int SEL_W = 4;

   // Register byte offsets
   localparam logic [ADR_W-1:0] OFS_CTRL      = 12'h000;
   localparam logic [ADR_W-1:0] OFS_GMASK     = 12'h004;
   localparam logic [ADR_W-1:0] OFS_HIGH_PRIO_MATCH_STATUS      = 12'h008;
   localparam logic [ADR_W-1:0] OFS_IRQ_STAT  = 12'h00c;
   localparam logic [ADR_W-1:0] OFS_IRQ_MASK  = 12'h010;
   localparam logic [ADR_W-1:0] OFS_RESULT    = 12'h014;
   localparam logic [ADR_W-1:0] OFS_ELEM_BASE = 12'h100;
   localparam int               ELEM_BYTES    = 8;

   // Element word layout
   localparam int CODE_MSB  = 31;
   localparam int CODE_LSB  = 29;
   localparam int FTYPE_MSB = 31;
   localparam int FTYPE_LSB = 30;
   localparam int IDENT_MSB = 28;
   localparam int IDENT_W   = 29;

   // Status field positions
   localparam int HIGH_PRIO_MATCH_STATUS_CODE_LSB = 8;
   localparam int HIGH_PRIO_MATCH_STATUS_EXT_BIT  = 15;
   localparam int RES_PRIO_BIT  = 8;
   localparam int RES_IDX_LSB   = 16;
   localparam int RES_HIT_BIT   = 31;

   // Interrupt bits
   localparam int IRQ_W        = 2;
   localparam int IRQ_HIGH_PRI = 0;
   localparam int IRQ_DONE     = 1;

   // Reset values
   localparam logic [7:0]         RST_LIST_SIZE = 8'h00;
   localparam logic [IDENT_W-1:0] RST_GMASK     = 29'h1fffffff;
   localparam logic [IRQ_W-1:0]   RST_IRQ_MASK  = 2'h0;

   // Element configuration codes
   typedef enum logic [2:0] {
      CFG_DISABLE        = 3'h0,
      CFG_STORE_FIFO0    = 3'h1,
      CFG_STORE_FIFO1    = 3'h2,
      CFG_REJECT         = 3'h3,
      CFG_PRIO_ONLY      = 3'h4,
      CFG_PRIO_FIFO0     = 3'h5,
      CFG_PRIO_FIFO1     = 3'h6,
      CFG_STORE_DEDI_BUF = 3'h7
   } cef_cfg_e;

   // Filter types
   typedef enum logic [1:0] {
      FT_MASKED_RANGE = 2'h0,
      FT_DUAL         = 2'h1,
      FT_CLASSIC      = 2'h2,
      FT_RANGE        = 2'h3
   } cef_ftype_e;

   // Filter decision
   typedef enum logic [2:0] {
      DEC_NO_MATCH = 3'h0,
      DEC_FIFO0    = 3'h1,
      DEC_FIFO1    = 3'h2,
      DEC_DEDI_BUF = 3'h3,
      DEC_REJECT   = 3'h4
   } cef_dec_e;

   // One filter element, word zero in the upper half
   typedef struct packed {
      cef_cfg_e           element_config_code;
      logic [IDENT_W-1:0] filter_ident_first;
      cef_ftype_e         filter_type_sel;
      logic [IDENT_W-1:0] filter_ident_second;
   } cef_elem_s;

   // Wishbone request from the master
   typedef struct packed {
      logic             cyc;
      logic             stb;
      logic             we;
      logic [ADR_W-1:0] adr;
      logic [SEL_W-1:0] sel;
      logic [DAT_W-1:0] dat;
   } cef_wb_req_s;

   // Result of one filter walk
   typedef struct packed {
      cef_dec_e   decision;
      logic       high_prio;
      logic       hit;
      logic [7:0] index;
   } cef_result_s;

endpackage

// file: verilog/cef_elem_match.sv
`timescale 1ns/10ps
module cef_elem_match
(
   // Element and frame
   input  wire cef_pkg::cef_elem_s         elem_i,
   input  wire logic [cef_pkg::IDENT_W-1:0] ident_i,
   input  wire logic [cef_pkg::IDENT_W-1:0] global_ext_ident_mask_i,
   // Verdict
   output logic                            match_o
);
   import cef_pkg::*;

   logic [IDENT_W-1:0] mid;
   logic [IDENT_W-1:0] id1;
   logic [IDENT_W-1:0] id2;
   logic               hit;

   always_comb
   begin
      mid = ident_i & global_ext_ident_mask_i;
      id1 = elem_i.filter_ident_first;
      id2 = elem_i.filter_ident_second;
      hit = 1'b0;
      if (elem_i.element_config_code == CFG_STORE_DEDI_BUF)
      begin
         hit = (mid == id1);
      end
      else
      begin
         case (elem_i.filter_type_sel)
            FT_MASKED_RANGE: hit = (mid >= id1) && (mid <= id2);
            FT_DUAL:         hit = (mid == id1) || (mid == id2);
            FT_CLASSIC:      hit = ((mid & id2) == (id1 & id2));
            FT_RANGE:        hit = (ident_i >= id1)
                                   && (ident_i <= id2);
            default:         hit = 1'b0;
         endcase
      end
      // Disabled elements never match
      match_o = hit && (elem_i.element_config_code != CFG_DISABLE);
   end

endmodule

// file: verilog/cef_ext_filter.sv
// Overview of operation
// - Enabled elements below the list size take part in filtering
// - Walk in order, stop at first match
// - Priority codes set flag, raise enabled interrupt
// - Priority match updates priority status register
// - Config code in word zero bits 31:29
// - Codes 0/1/2: disable, FIFO 0, FIFO 1
// - Code 3 rejects a matching frame
// - Codes 4/5/6 mark priority, 5/6 also store
// - Code 7 dedicated buffer, type ignored
// - First identifier in word zero bits 28:0
// - Code 7 needs exact masked identifier match
// - Filter type in word one bits 31:30
// - Type 0 masked inclusive range compare
// - Type 1 matches either identifier
// - Type 2 pattern and mask compare
// - Type 3 range compare without global mask
// - Second identifier in word one bits 28:0
`timescale 1ns/10ps
module cef_ext_filter
#(
   parameter int MAX_ELEM = 16
)
(
   // Clock and reset
   input  wire logic                          clk_i,
   input  wire logic                          rst_i,
   // Wishbone slave
   input  wire cef_pkg::cef_wb_req_s          wb_req_i,
   output logic                               wb_ack_o,
   output logic [cef_pkg::DAT_W-1:0]          wb_dat_o,
   // Received extended frame
   input  wire logic                          frm_valid_i,
   input  wire logic [cef_pkg::IDENT_W-1:0]   frm_ident_i,
   output logic                               frm_ready_o,
   // Filter result
   output logic                               res_valid_o,
   output cef_pkg::cef_result_s               res_o,
   // Interrupt
   output logic                               irq_o
);
   import cef_pkg::*;

   localparam int IW = $clog2(MAX_ELEM);

   // The index is 8 bits wide and element addresses stop below 0x500
   generate
      if (MAX_ELEM < 2 || MAX_ELEM > 128)
      begin : g_bad_size
         $error("MAX_ELEM must lie between 2 and 128");
      end
   endgenerate

   // Register merges below assume a 32-bit bus with byte lanes
   generate
      if (DAT_W != 32 || SEL_W * 8 != DAT_W)
      begin : g_bad_bus
         $error("register bus must be 32 bits with byte lanes");
      end
   endgenerate

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_WALK
   } cef_state_e;

   typedef struct packed {
      cef_state_e                  state;
      logic [7:0]                  idx;
      logic [IDENT_W-1:0]          rx_ident;
      logic [7:0]                  list_size;
      logic [IDENT_W-1:0]          gmask;
      logic [15:0]                 high_prio_match_status;
      logic [IRQ_W-1:0]            irq_stat;
      logic [IRQ_W-1:0]            irq_mask;
      cef_result_s                 res;
      logic                        res_vld;
      logic                        ack;
      logic [DAT_W-1:0]            rdat;
      logic [MAX_ELEM-1:0][63:0]   mem;
   } cef_state_s;

   cef_state_s st_ff;
   cef_state_s nxt_st;

   cef_elem_s  cur_elem;
   logic       cur_match;
   logic       bus_req;
   logic       bus_wr;
   logic [DAT_W-1:0] byte_mask;
   logic [ADR_W-1:0] elem_rel;
   logic [ADR_W-4:0] elem_sel;
   logic       elem_hit;
   logic [IRQ_W-1:0] irq_set;
   logic [DAT_W-1:0] word_zero;
   logic [DAT_W-1:0] word_one;

   // Element under test; idx stays below MAX_ELEM, since list_size is clamped.
   // Fields are cut out one by one: bit 29 of word one is spare, so the
   // 64-bit entry cannot be laid straight onto the 63-bit element.
   assign word_zero = st_ff.mem[st_ff.idx[IW-1:0]][63:32];
   assign word_one  = st_ff.mem[st_ff.idx[IW-1:0]][31:0];
   assign cur_elem  = {word_zero[CODE_MSB:CODE_LSB],
                       word_zero[IDENT_MSB:0],
                       word_one[FTYPE_MSB:FTYPE_LSB],
                       word_one[IDENT_MSB:0]};

   cef_elem_match cef_elem_match_inst
   (
      .elem_i                  (cur_elem),
      .ident_i                 (st_ff.rx_ident),
      .global_ext_ident_mask_i (st_ff.gmask),
      .match_o                 (cur_match)
   );

   // Byte enables widened to a bit mask, one lane per sel bit
   genvar gb;
   generate
      for (gb = 0; gb < SEL_W; gb = gb + 1)
      begin : g_lane
         assign byte_mask[gb*8 +: 8] = {8{wb_req_i.sel[gb]}};
      end
   endgenerate

   // Ack high masks the request, so a held strobe is not taken twice
   assign bus_req  = wb_req_i.cyc && wb_req_i.stb && !st_ff.ack;
   assign bus_wr   = bus_req && wb_req_i.we;
   assign elem_rel = wb_req_i.adr - OFS_ELEM_BASE;
   assign elem_sel = elem_rel[ADR_W-1:3];
   assign elem_hit = (wb_req_i.adr >= OFS_ELEM_BASE)
                     && (elem_sel < (ADR_W-3)'(MAX_ELEM));

   // Byte lanes not selected keep their old contents
   function automatic logic [DAT_W-1:0] merge
   (
      input logic [DAT_W-1:0] old_v,
      input logic [DAT_W-1:0] new_v,
      input logic [DAT_W-1:0] bm
   );
      merge = (old_v & ~bm) | (new_v & bm);
   endfunction

   always_comb
   begin
      logic [DAT_W-1:0] wv;
      logic [63:0]      ev;
      wv      = '0;
      ev      = '0;
      irq_set = '0;
      nxt_st  = st_ff;
      nxt_st.res_vld = 1'b0;
      nxt_st.ack     = bus_req;

      // Filter walk
      case (st_ff.state)
         ST_IDLE:
         begin
            if (frm_valid_i)
            begin
               nxt_st.rx_ident = frm_ident_i;
               nxt_st.idx      = 8'h00;
               nxt_st.state    = ST_WALK;
            end
         end
         ST_WALK:
         begin
            if (st_ff.list_size == 8'h00)
            begin
               nxt_st.res.decision  = DEC_NO_MATCH;
               nxt_st.res.high_prio = 1'b0;
               nxt_st.res.hit       = 1'b0;
               nxt_st.res.index     = 8'h00;
               nxt_st.res_vld       = 1'b1;
               nxt_st.state         = ST_IDLE;
            end
            else if (cur_match)
            begin
               // First enabled match ends the search
               nxt_st.res.hit       = 1'b1;
               nxt_st.res.index     = st_ff.idx;
               nxt_st.res.high_prio = 1'b0;
               nxt_st.res_vld       = 1'b1;
               nxt_st.state         = ST_IDLE;
               case (cur_elem.element_config_code)
                  CFG_STORE_FIFO0:
                     nxt_st.res.decision = DEC_FIFO0;
                  CFG_STORE_FIFO1:
                     nxt_st.res.decision = DEC_FIFO1;
                  CFG_REJECT:
                     nxt_st.res.decision = DEC_REJECT;
                  // Priority-only hits store nothing but still end the walk
                  CFG_PRIO_ONLY:
                     nxt_st.res.decision = DEC_NO_MATCH;
                  CFG_PRIO_FIFO0:
                     nxt_st.res.decision = DEC_FIFO0;
                  CFG_PRIO_FIFO1:
                     nxt_st.res.decision = DEC_FIFO1;
                  CFG_STORE_DEDI_BUF:
                     nxt_st.res.decision = DEC_DEDI_BUF;
                  default:
                     nxt_st.res.decision = DEC_NO_MATCH;
               endcase
               if (cur_elem.element_config_code == CFG_PRIO_ONLY
                   || cur_elem.element_config_code == CFG_PRIO_FIFO0
                   || cur_elem.element_config_code == CFG_PRIO_FIFO1)
               begin
                  nxt_st.res.high_prio = 1'b1;
                  irq_set[IRQ_HIGH_PRI] = 1'b1;
                  // Status keeps the last priority hit until the next one
                  nxt_st.high_prio_match_status = '0;
                  nxt_st.high_prio_match_status[7:0] = st_ff.idx;
                  nxt_st.high_prio_match_status[HIGH_PRIO_MATCH_STATUS_CODE_LSB +: 3] =
                     cur_elem.element_config_code;
                  nxt_st.high_prio_match_status[HIGH_PRIO_MATCH_STATUS_EXT_BIT] = 1'b1;
               end
            end
            else if (st_ff.idx >= st_ff.list_size - 8'h01)
            begin
               // End of list reached without a match; >= also ends a walk
               // whose list was shortened while it ran
               nxt_st.res.decision  = DEC_NO_MATCH;
               nxt_st.res.high_prio = 1'b0;
               nxt_st.res.hit       = 1'b0;
               nxt_st.res.index     = st_ff.idx;
               nxt_st.res_vld       = 1'b1;
               nxt_st.state         = ST_IDLE;
            end
            else
            begin
               nxt_st.idx = st_ff.idx + 8'h01;
            end
         end
         default:
         begin
            nxt_st.state = ST_IDLE;
         end
      endcase
      irq_set[IRQ_DONE] = nxt_st.res_vld;

      // Register writes take effect on the accepting edge
      if (bus_wr)
      begin
         case (wb_req_i.adr)
            OFS_CTRL:
            begin
               wv = merge({24'h0, st_ff.list_size}, wb_req_i.dat,
                          byte_mask);
               // Clamp so the walk never indexes past storage
               if (wv[7:0] > 8'(MAX_ELEM))
                  nxt_st.list_size = 8'(MAX_ELEM);
               else
                  nxt_st.list_size = wv[7:0];
            end
            OFS_GMASK:
            begin
               wv = merge({3'h0, st_ff.gmask}, wb_req_i.dat, byte_mask);
               nxt_st.gmask = wv[IDENT_W-1:0];
            end
            OFS_IRQ_MASK:
            begin
               wv = merge({30'h0, st_ff.irq_mask}, wb_req_i.dat,
                          byte_mask);
               nxt_st.irq_mask = wv[IRQ_W-1:0];
            end
            default:
            begin
               if (elem_hit)
               begin
                  ev = st_ff.mem[elem_sel[IW-1:0]];
                  if (elem_rel[2])
                     ev[31:0] = merge(ev[31:0], wb_req_i.dat,
                                      byte_mask);
                  else
                     ev[63:32] = merge(ev[63:32], wb_req_i.dat,
                                       byte_mask);
                  nxt_st.mem[elem_sel[IW-1:0]] = ev;
               end
            end
         endcase
      end

      // Write one to clear; a new event in the same cycle wins
      nxt_st.irq_stat = st_ff.irq_stat;
      if (bus_wr && wb_req_i.adr == OFS_IRQ_STAT && wb_req_i.sel[0])
         nxt_st.irq_stat = st_ff.irq_stat & ~wb_req_i.dat[IRQ_W-1:0];
      nxt_st.irq_stat = nxt_st.irq_stat | irq_set;

      // Read data, registered with the acknowledge
      if (bus_req)
      begin
         case (wb_req_i.adr)
            OFS_CTRL:     nxt_st.rdat = {24'h0, st_ff.list_size};
            OFS_GMASK:    nxt_st.rdat = {3'h0, st_ff.gmask};
            OFS_HIGH_PRIO_MATCH_STATUS:     nxt_st.rdat = {16'h0, st_ff.high_prio_match_status};
            OFS_IRQ_STAT: nxt_st.rdat = {30'h0, st_ff.irq_stat};
            OFS_IRQ_MASK: nxt_st.rdat = {30'h0, st_ff.irq_mask};
            OFS_RESULT:
            begin
               nxt_st.rdat = '0;
               nxt_st.rdat[2:0] = st_ff.res.decision;
               nxt_st.rdat[RES_PRIO_BIT] = st_ff.res.high_prio;
               nxt_st.rdat[RES_IDX_LSB +: 8] = st_ff.res.index;
               nxt_st.rdat[RES_HIT_BIT] = st_ff.res.hit;
            end
            default:
            begin
               nxt_st.rdat = '0;
               if (elem_hit)
               begin
                  ev = st_ff.mem[elem_sel[IW-1:0]];
                  nxt_st.rdat = elem_rel[2] ? ev[31:0] : ev[63:32];
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         // Clearing the entries leaves every element disabled
         st_ff           <= '0;
         st_ff.state     <= ST_IDLE;
         st_ff.list_size <= RST_LIST_SIZE;
         st_ff.gmask     <= RST_GMASK;
         st_ff.irq_mask  <= RST_IRQ_MASK;
      end
      else
      begin
         st_ff <= nxt_st;
      end
   end

   // New frames wait while a walk is running
   assign frm_ready_o = (st_ff.state == ST_IDLE);
   assign res_valid_o = st_ff.res_vld;
   assign res_o       = st_ff.res;
   // Ack comes from a flop, so each access costs one wait cycle
   assign wb_ack_o    = st_ff.ack;
   assign wb_dat_o    = st_ff.rdat;
   assign irq_o       = |(st_ff.irq_stat & st_ff.irq_mask);

endmodule

// file: bench/cef_ext_filter_monitor.sv
`timescale 1ns/10ps
module cef_ext_filter_monitor
#(
   parameter int MAX_ELEM = 16
)
(
   // Clock and reset
   input  wire logic                        clk_i,
   input  wire logic                        rst_i,
   // Wishbone
   input  wire cef_pkg::cef_wb_req_s        wb_req_i,
   input  wire logic                        wb_ack_o,
   input  wire logic [cef_pkg::DAT_W-1:0]   wb_dat_o,
   // Frame and result
   input  wire logic                        frm_valid_i,
   input  wire logic [cef_pkg::IDENT_W-1:0] frm_ident_i,
   input  wire logic                        frm_ready_o,
   input  wire logic                        res_valid_o,
   input  wire cef_pkg::cef_result_s        res_o,
   input  wire logic                        irq_o
);
   import cef_pkg::*;

   // Result lands one sample later than the walk length
   localparam int RES_MAX = MAX_ELEM + 1;

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   AST_WB_ANSWER:
      assert property (wb_req_i.cyc && wb_req_i.stb && !wb_ack_o |=> wb_ack_o)
      else $error("bus request not answered next cycle");
   AST_WB_PULSE:
      assert property (wb_ack_o |=> !wb_ack_o)
      else $error("bus ack longer than one cycle");
   AST_FRM_BUSY:
      assert property (frm_valid_i && frm_ready_o |=> !frm_ready_o)
      else $error("frame taken but ready stayed high");
   AST_FRM_BOUND:
      assert property (frm_valid_i && frm_ready_o
         |-> ##[2:RES_MAX] res_valid_o)
      else $error("filter walk overran the list");
   AST_RES_READY:
      assert property (res_valid_o |-> frm_ready_o && !$past(frm_ready_o))
      else $error("result without a walk in progress");
   AST_RES_HOLD:
      assert property (!res_valid_o |-> $stable(res_o))
      else $error("result changed without a valid pulse");
   AST_PRIO_KIND:
      assert property (res_valid_o && res_o.high_prio |-> res_o.hit &&
         res_o.decision inside {DEC_NO_MATCH, DEC_FIFO0, DEC_FIFO1})
      else $error("priority result with wrong decision");
   AST_REJECT:
      assert property (res_valid_o && res_o.decision == DEC_REJECT
         |-> res_o.hit && !res_o.high_prio)
      else $error("reject result malformed");
   AST_MISS:
      assert property (res_valid_o && !res_o.hit
         |-> res_o.decision == DEC_NO_MATCH && !res_o.high_prio)
      else $error("miss result carries a decision");

   COV_IRQ: cover property (res_valid_o && res_o.high_prio && irq_o);
   COV_RD:  cover property (wb_ack_o && wb_dat_o != '0);
   COV_ID:  cover property (frm_valid_i && frm_ident_i == '0);
endmodule

// file: bench/cef_frame_src.sv
`timescale 1ns/10ps
module cef_frame_src
(
   // Clock
   input  wire logic                        clk_i,
   // Handshake toward the filter
   input  wire logic                        ready_i,
   output logic                             valid_o,
   output logic [cef_pkg::IDENT_W-1:0]      ident_o
);
   import cef_pkg::*;

   initial
   begin
      valid_o = 1'b0;
      ident_o = '0;
   end

   // Offer one identifier, hold it until the filter takes it
   task send(input logic [IDENT_W-1:0] id, input int gap);
      int n;
      n = 0;
      repeat (gap) @(posedge clk_i);
      valid_o <= 1'b1;
      ident_o <= id;
      do
      begin
         @(posedge clk_i);
         n++;
      end
      while (ready_i !== 1'b1 && n < 100);
      valid_o <= 1'b0;
      // Inverted so a stale identifier can never look valid
      ident_o <= ~id;
   endtask
endmodule

// file: bench/test_cef_ext_filter.sv
`timescale 1ns/10ps
module test_cef_ext_filter;
   import cef_pkg::*;
   localparam int NEL = 8;
   logic               clk_i;
   logic               rst_i;
   cef_wb_req_s        wb_req_i;
   logic               wb_ack_o;
   logic [DAT_W-1:0]   wb_dat_o;
   logic               frm_valid_i;
   logic [IDENT_W-1:0] frm_ident_i;
   logic               frm_ready_o;
   logic               res_valid_o;
   cef_result_s        res_o;
   logic               irq_o;
   logic [DAT_W-1:0]   rd;
   int                 bad_count;
   int                 compares;
   int                 lsz;

   cef_ext_filter #(.MAX_ELEM(NEL)) cef_ext_filter_inst (
      .clk_i, .rst_i, .wb_req_i, .wb_ack_o, .wb_dat_o, .frm_valid_i,
      .frm_ident_i, .frm_ready_o, .res_valid_o, .res_o, .irq_o);

   cef_frame_src cef_frame_src_inst (.clk_i, .ready_i(frm_ready_o),
      .valid_o(frm_valid_i), .ident_o(frm_ident_i));

   initial
   begin
      clk_i = 1'b0;
      forever #10 clk_i = ~clk_i;
   end

   task check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task test_done;
      $display("Compares %0d, mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task wb(input logic we, input logic [ADR_W-1:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      wb_req_i <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hf, dat: d};
      do
      begin
         @(posedge clk_i);
         n++;
      end
      while (wb_ack_o !== 1'b1 && n < 50);
      rd = wb_dat_o;
      wb_req_i <= '0;
      if (wb_ack_o !== 1'b1)
      begin
         bad_count++;
         test_done;
      end
   endtask

   task rdchk(input logic [ADR_W-1:0] a, input logic [31:0] e);
      wb(1'b0, a, '0);
      check(rd, e);
   endtask

   task elem(input int i, input cef_cfg_e c, input logic [28:0] a,
             input cef_ftype_e t, input logic [28:0] b);
      logic [ADR_W-1:0] ea;
      ea = OFS_ELEM_BASE + ADR_W'(ELEM_BYTES * i);
      wb(1'b1, ea, {c, a});
      // Spare bit 29 set so a sloppy slice shows up
      wb(1'b1, ea + 12'h004, {t, 1'b1, b});
   endtask

   // Index is not compared on a miss, it carries no meaning there
   task frm(input logic [28:0] id, input cef_dec_e d, input logic h,
            input logic p, input logic [7:0] ix);
      int n;
      int lat;
      logic [31:0] rm;
      logic [31:0] qm;
      n = 0;
      lat = h ? int'(ix) + 1 : ((lsz == 0) ? 1 : lsz);
      rm = h ? 32'hffffffff : 32'h00001f00;
      qm = h ? 32'hffffffff : 32'h80000107;
      cef_frame_src_inst.send(id, int'(ix[1:0]));
      do
      begin
         @(posedge clk_i);
         n++;
      end
      while (res_valid_o !== 1'b1 && n < 200);
      if (res_valid_o !== 1'b1)
      begin
         bad_count++;
         test_done;
      end
      check(32'(n), 32'(lat + 1));
      check(32'(res_o) & rm, 32'({d, p, h, ix}) & rm);
      wb(1'b0, OFS_RESULT, '0);
      check(rd & qm, {h, 7'h0, ix, 7'h0, p, 5'h0, d} & qm);
   endtask

   initial
   begin
      wb_req_i = '0;
      rst_i = 1'b1;
      bad_count = 0;
      compares = 0;
      lsz = 0;
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      rdchk(OFS_CTRL, 32'h0);
      rdchk(OFS_GMASK, 32'h1fffffff);
      rdchk(OFS_IRQ_MASK, 32'h0);
      rdchk(12'h020, 32'h0);
      frm(29'h100, DEC_NO_MATCH, 1'b0, 1'b0, 8'h0);
      $display("Test reset done");
      elem(0, CFG_DISABLE, 29'h100, FT_DUAL, 29'h100);
      elem(1, CFG_REJECT, 29'h100, FT_DUAL, 29'h101);
      elem(2, CFG_STORE_FIFO0, 29'h200, FT_MASKED_RANGE, 29'h2ef);
      elem(3, CFG_STORE_FIFO1, 29'ha000, FT_CLASSIC, 29'h1ffff000);
      elem(4, CFG_PRIO_ONLY, 29'h300, FT_DUAL, 29'h301);
      elem(5, CFG_PRIO_FIFO0, 29'h400, FT_RANGE, 29'h40f);
      elem(6, CFG_PRIO_FIFO1, 29'h500, FT_DUAL, 29'h501);
      elem(7, CFG_STORE_DEDI_BUF, 29'h600, FT_CLASSIC, 29'h0);
      wb(1'b1, OFS_CTRL, 32'(NEL));
      lsz = NEL;
      frm(29'h100, DEC_REJECT, 1'b1, 1'b0, 8'h1);
      frm(29'h101, DEC_REJECT, 1'b1, 1'b0, 8'h1);
      frm(29'h200, DEC_FIFO0, 1'b1, 1'b0, 8'h2);
      frm(29'h2ef, DEC_FIFO0, 1'b1, 1'b0, 8'h2);
      frm(29'h2f0, DEC_NO_MATCH, 1'b0, 1'b0, 8'h0);
      frm(29'ha5a5, DEC_FIFO1, 1'b1, 1'b0, 8'h3);
      frm(29'h300, DEC_NO_MATCH, 1'b1, 1'b1, 8'h4);
      frm(29'h40f, DEC_FIFO0, 1'b1, 1'b1, 8'h5);
      frm(29'h410, DEC_NO_MATCH, 1'b0, 1'b0, 8'h0);
      frm(29'h500, DEC_FIFO1, 1'b1, 1'b1, 8'h6);
      frm(29'h600, DEC_DEDI_BUF, 1'b1, 1'b0, 8'h7);
      frm(29'h601, DEC_NO_MATCH, 1'b0, 1'b0, 8'h0);
      $display("Test decode done");
      wb(1'b1, OFS_GMASK, 32'h1fffffef);
      frm(29'h2f5, DEC_FIFO0, 1'b1, 1'b0, 8'h2);
      frm(29'h410, DEC_NO_MATCH, 1'b0, 1'b0, 8'h0);
      frm(29'h610, DEC_DEDI_BUF, 1'b1, 1'b0, 8'h7);
      frm(29'h311, DEC_NO_MATCH, 1'b1, 1'b1, 8'h4);
      $display("Test mask done");
      check(32'(irq_o), 32'h0);
      rdchk(OFS_IRQ_STAT, 32'h3);
      rdchk(OFS_HIGH_PRIO_MATCH_STATUS, 32'h8404);
      wb(1'b1, OFS_IRQ_STAT, 32'h3);
      rdchk(OFS_IRQ_STAT, 32'h0);
      wb(1'b1, OFS_IRQ_MASK, 32'h1);
      check(32'(irq_o), 32'h0);
      frm(29'h501, DEC_FIFO1, 1'b1, 1'b1, 8'h6);
      check(32'(irq_o), 32'h1);
      rdchk(OFS_HIGH_PRIO_MATCH_STATUS, 32'h8606);
      wb(1'b1, OFS_IRQ_STAT, 32'h1);
      check(32'(irq_o), 32'h0);
      rdchk(OFS_IRQ_STAT, 32'h2);
      $display("Test interrupt done");
      test_done;
   end
endmodule

bind cef_ext_filter cef_ext_filter_monitor #(.MAX_ELEM(MAX_ELEM))
   cef_ext_filter_monitor_inst (.clk_i, .rst_i, .wb_req_i, .wb_ack_o,
   .wb_dat_o, .frm_valid_i, .frm_ident_i, .frm_ready_o, .res_valid_o,
   .res_o, .irq_o);
